/* File: src/sic_pkg.sv */
// Shared constants, types and register map of the stepper indexer block
package sic_pkg;
  // Clock and overcurrent dwell time
  localparam int CLK_PERIOD_NS = 10;
  localparam int OC_TIME_NS = 3000;
  localparam int OC_CYCLES_CALC =
    (OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CYCLES_MIN1 = (OC_CYCLES_CALC < 1) ? 1 : OC_CYCLES_CALC;

  // Microstep table geometry
  localparam int PTR_W = 7;
  localparam logic [PTR_W-1:0] HOME_PTR = 7'h10;
  localparam logic [PTR_W-1:0] FULL_STRIDE = 7'h20;
  localparam logic [2:0] MODE_FINEST = 3'h5;
  localparam int FET_N = 8;

  // Register map, byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_INT_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_INT_ENABLE = 32'h0000_0008;
  localparam logic [31:0] ADDR_INT_CLEAR = 32'h0000_000c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_W = 4;

  // Resolution select
  typedef enum logic [2:0] {
    SIC_FULL = 3'h0,
    SIC_HALF = 3'h1,
    SIC_QUARTER = 3'h2,
    SIC_EIGHTH = 3'h3,
    SIC_SIXTEENTH = 3'h4,
    SIC_THIRTYSECOND = 3'h5
  } sic_mode_e;

  // Controller pins
  typedef struct packed {
    logic step_in;
    logic dir_in;
    logic [2:0] mode;
    logic chip_clear_low;
    logic output_enable_low;
    logic sleep_request_low;
  } sic_pins_s;

  // Power stage controls
  typedef struct packed {
    logic [1:0] bridge_en;
    logic outputs_hiz;
    logic charge_pump_on;
    logic aux_regulator_on;
  } sic_drive_s;

  // Interrupt event bits
  typedef struct packed {
    logic step_done;
    logic supply_low;
    logic thermal;
    logic overcurrent;
  } sic_irq_s;

  // Status word layout
  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic bridges_on;
    logic supply_low;
    logic thermal;
    logic overcurrent;
    logic [4:0] rsvd_mid;
    logic [2:0] mode;
    logic rsvd_lo;
    logic [PTR_W-1:0] ptr;
  } sic_status_s;

  typedef logic signed [7:0] sic_pct_t;
endpackage

/* File: src/sic_input_sync.sv */
// Two-stage synchroniser with rising edge detect on bit zero
`timescale 1ns/10ps
module sic_input_sync #(
  parameter int W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic rise
);
  logic [W-1:0] meta_reg; // First stage, read only by second
  logic [W-1:0] sync_reg; // Second stage
  logic prev_reg; // Delayed bit zero for edge detect

  // Stages only; the edge is taken from settled data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[0];
    end
  end

  assign dout = sync_reg;
  assign rise = sync_reg[0] & ~prev_reg;
endmodule

/* File: src/sic_current_table.sv */
// Winding current lookup for the 128-entry microstep table
`timescale 1ns/10ps
module sic_current_table (
  input wire logic [6:0] ptr,
  output sic_pkg::sic_pct_t coil_a,
  output sic_pkg::sic_pct_t coil_b
);
  import sic_pkg::*;

  // Quarter sine in percent, entry 32 first
  localparam logic [8*33-1:0] QTAB = {
    8'h64, 8'h64, 8'h64, 8'h63, 8'h62, 8'h61, 8'h60, 8'h5e, 8'h5c,
    8'h5a, 8'h58, 8'h56, 8'h53, 8'h50, 8'h4d, 8'h4a, 8'h47, 8'h43,
    8'h3f, 8'h3c, 8'h38, 8'h33, 8'h2f, 8'h2b, 8'h26, 8'h22, 8'h1d,
    8'h18, 8'h14, 8'h0f, 8'h0a, 8'h05, 8'h00};

  // Signed sine of a pointer, one count per 2.8125 degrees
  function automatic sic_pct_t sine_pct(input logic [6:0] p);
    logic [5:0] idx;
    logic [7:0] mag;
    idx = p[5] ? (6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
    mag = QTAB[idx*8 +: 8];
    sine_pct = p[6] ? sic_pct_t'(-mag) : sic_pct_t'(mag);
  endfunction

  // Winding A leads winding B by a quarter turn
  assign coil_a = sine_pct(ptr + FULL_STRIDE);
  assign coil_b = sine_pct(ptr);
endmodule

/* File: src/sic_indexer.sv */
// Stepper indexer: step/dir control, protection latches, AXI4-Lite regs
// How it works
// [RQ1] Chip clear resets logic, pointer goes home
// [RQ2] Chip clear disables bridges, ignores steps
// [RQ3] Enable low: bridges on, steps recognised
// [RQ4] Enable high: bridges off, high impedance, steps ignored
// [RQ5] Sleep: everything off, all inputs ignored; here thermal_cutoff still pulls fault_flag_low and lockout still resets
// [RQ6] Controller waits about 1 ms after sleep
// [RQ7] Controller holds sleep and clear high
// [RQ8] Persistent current limit trips shutdown and fault
// [RQ9] Overcurrent latch held until clear or supply loss
// [RQ10] Any high or low side FET trips
// [RQ11] Thermal disables bridges, fault, self-recovers
// [RQ12] Supply lockout resets logic, resumes afterwards
// [RQ13] Each recognised step moves exactly one state
// [RQ14] Direction level picks forward or backward
// [RQ15] Three mode bits pick full to 1/32
// [RQ16] Index 113 gives A +71%, B -71%
// [RQ17] Index 97 gives A 0%, B -100%
// [RQ18] Step and direction synchronised, edge detected
// [RQ19] Coarser modes stride 2..32 with wraparound
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module sic_indexer #(
  parameter int OC_CYCLES = sic_pkg::OC_CYCLES_MIN1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input sic_pkg::sic_pins_s pins,
  input wire logic [sic_pkg::FET_N-1:0] fet_current_limit,
  input wire logic thermal_cutoff,
  input wire logic supply_low_lockout,
  output sic_pkg::sic_drive_s drive,
  output sic_pkg::sic_pct_t coil_a,
  output sic_pkg::sic_pct_t coil_b,
  output logic fault_flag_low,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sic_pkg::*;

  localparam int CNT_W = $clog2(OC_CYCLES + 1);
  localparam logic [CNT_W-1:0] OC_LAST = CNT_W'(OC_CYCLES - 1);

  // Stride for the selected resolution; reserved codes act as 1/32
  function automatic logic [PTR_W-1:0] stride(input logic [2:0] m);
    logic [2:0] lim;
    lim = (m > MODE_FINEST) ? MODE_FINEST : m;
    stride = FULL_STRIDE >> lim; // see [RQ15] [RQ19]
  endfunction

  // Pointer after one step; the 7-bit sum wraps at either end
  function automatic logic [PTR_W-1:0] step_ptr(
    input logic [PTR_W-1:0] p, input logic d, input logic [2:0] m);
    step_ptr = d ? (p + stride(m)) : (p - stride(m));
  endfunction

  // Word match of a full byte address
  function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
    hit = ({a[31:2], 2'h0} == t);
  endfunction

  // Synchronised step, direction and mode
  logic [4:0] sync_q; // Settled {mode, dir, step}
  logic step_rise; // One-cycle pulse per step edge
  logic dir_s; // Settled direction
  logic [2:0] mode_s; // Settled resolution

  sic_input_sync #(.W(5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({pins.mode, pins.dir_in, pins.step_in}),
    .dout(sync_q),
    .rise(step_rise)
  );
  assign dir_s = sync_q[1];
  assign mode_s = sync_q[4:2];

  // Table lookup of the present pointer
  logic [PTR_W-1:0] ptr_reg, ptr_next; // Microstep table position
  sic_pct_t tab_a; // Winding A command
  sic_pct_t tab_b; // Winding B command

  sic_current_table u_table (
    .ptr(ptr_reg),
    .coil_a(tab_a),
    .coil_b(tab_b)
  );

  // Motion and protection state
  logic [CNT_W-1:0] oc_cnt_reg, oc_cnt_next; // Limit dwell counter
  logic oc_trip_reg, oc_trip_next; // Latched overcurrent shutdown
  logic thermal_reg, thermal_next; // Previous thermal level
  logic uv_reg, uv_next; // Previous lockout level
  sic_drive_s drive_reg, drive_next;
  sic_pct_t coil_a_reg, coil_a_next;
  sic_pct_t coil_b_reg, coil_b_next;
  logic fault_low_reg, fault_low_next;
  logic bridges_on; // Both bridges may conduct
  logic step_ok; // A step is accepted this cycle
  logic awake; // Clocks run, inputs honoured
  sic_irq_s events; // One-cycle event pulses

  // Next state of motion and protection
  always_comb begin
    ptr_next = ptr_reg;
    oc_cnt_next = oc_cnt_reg;
    oc_trip_next = oc_trip_reg;
    step_ok = 1'b0;
    awake = pins.sleep_request_low & ~supply_low_lockout;
    if (supply_low_lockout) begin
      // Lockout wipes logic like a power cycle
      ptr_next = HOME_PTR; // see [RQ12]
      oc_cnt_next = '0;
      oc_trip_next = 1'b0; // see [RQ9]
    end else if (!pins.sleep_request_low) begin
      // Clocks notionally stopped: freeze everything
      ptr_next = ptr_reg; // see [RQ5]
    end else if (!pins.chip_clear_low) begin
      // Clear: home pointer, drop latch, no stepping
      ptr_next = HOME_PTR; // see [RQ1] [RQ2]
      oc_cnt_next = '0;
      oc_trip_next = 1'b0; // see [RQ9]
    end else begin
      // Any single FET limit counts, high or low side
      if (|fet_current_limit && !oc_trip_reg) begin // see [RQ10]
        if (oc_cnt_reg == OC_LAST) begin
          oc_trip_next = 1'b1; // see [RQ8]
        end else begin
          oc_cnt_next = oc_cnt_reg + 1'b1;
        end
      end else begin
        oc_cnt_next = '0;
      end
      // Steps count only while outputs enabled
      if (step_rise && !pins.output_enable_low) begin // see [RQ3] [RQ18]
        step_ok = 1'b1;
        ptr_next = step_ptr(ptr_reg, dir_s, mode_s); // see [RQ13] [RQ14]
      end
    end
    bridges_on = awake & pins.chip_clear_low & ~pins.output_enable_low &
                 ~oc_trip_next & ~thermal_cutoff; // see [RQ4] [RQ11]
    drive_next.bridge_en = {2{bridges_on}};
    drive_next.outputs_hiz = ~bridges_on;
    drive_next.charge_pump_on = awake; // see [RQ5]
    drive_next.aux_regulator_on = awake;
    fault_low_next = ~(oc_trip_next | thermal_cutoff); // see [RQ8] [RQ11]
    coil_a_next = tab_a; // see [RQ16] [RQ17]
    coil_b_next = tab_b;
    thermal_next = thermal_cutoff;
    uv_next = supply_low_lockout;
    events.overcurrent = oc_trip_next & ~oc_trip_reg;
    events.thermal = thermal_cutoff & ~thermal_reg;
    events.supply_low = supply_low_lockout & ~uv_reg;
    events.step_done = step_ok;
  end

  // Registers of motion and protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= HOME_PTR;
      oc_cnt_reg <= '0;
      oc_trip_reg <= 1'b0;
      thermal_reg <= 1'b0;
      uv_reg <= 1'b0;
      drive_reg <= '0;
      coil_a_reg <= '0;
      coil_b_reg <= '0;
      fault_low_reg <= 1'b1;
    end else begin
      ptr_reg <= ptr_next;
      oc_cnt_reg <= oc_cnt_next;
      oc_trip_reg <= oc_trip_next;
      thermal_reg <= thermal_next;
      uv_reg <= uv_next;
      drive_reg <= drive_next;
      coil_a_reg <= coil_a_next;
      coil_b_reg <= coil_b_next;
      fault_low_reg <= fault_low_next;
    end
  end

  assign drive = drive_reg;
  assign coil_a = coil_a_reg;
  assign coil_b = coil_b_reg;
  assign fault_flag_low = fault_low_reg;

  // Bus slave and interrupt state
  logic aw_held_reg, aw_held_next; // Write address captured
  logic [31:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next; // Write data captured
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  sic_irq_s int_st_reg, int_st_next; // Sticky events
  sic_irq_s int_en_reg, int_en_next; // Interrupt mask
  logic irq_reg, irq_next;
  sic_irq_s clr_mask; // Bits cleared by software this cycle
  sic_status_s stat; // Live status word
  logic do_write; // Both halves present, response slot free

  // Next state of bus slave and interrupts
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    int_en_next = int_en_reg;
    clr_mask = '0;
    stat = '0;
    stat.bridges_on = drive_reg.bridge_en[0];
    stat.supply_low = supply_low_lockout;
    stat.thermal = thermal_cutoff;
    stat.overcurrent = oc_trip_reg;
    stat.mode = mode_s;
    stat.ptr = ptr_reg;
    // Address and data are taken in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Write commits only once the old response is gone
    do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (hit(aw_addr_reg, ADDR_INT_ENABLE)) begin
        if (w_strb_reg[0]) begin
          int_en_next = w_data_reg[IRQ_W-1:0];
        end
      end else if (hit(aw_addr_reg, ADDR_INT_CLEAR)) begin
        if (w_strb_reg[0]) begin
          clr_mask = w_data_reg[IRQ_W-1:0];
        end
      end else if (!hit(aw_addr_reg, ADDR_STATUS) &&
                   !hit(aw_addr_reg, ADDR_INT_STATUS)) begin
        // Read-only words ignore writes; holes answer an error
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
    // Read path, one outstanding
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      if (hit(s_axi_araddr, ADDR_STATUS)) begin
        rdata_next = stat;
      end else if (hit(s_axi_araddr, ADDR_INT_STATUS)) begin
        rdata_next = {{(32-IRQ_W){1'b0}}, int_st_reg};
      end else if (hit(s_axi_araddr, ADDR_INT_ENABLE)) begin
        rdata_next = {{(32-IRQ_W){1'b0}}, int_en_reg};
      end else if (hit(s_axi_araddr, ADDR_INT_CLEAR)) begin
        rdata_next = '0; // Clear word reads as zero
      end else begin
        rdata_next = '0;
        rresp_next = RESP_SLVERR;
      end
    end
    arready_next = ~rvalid_next;
    // A new event beats a clear in the same cycle
    int_st_next = (int_st_reg & ~clr_mask) | events;
    irq_next = |(int_st_next & int_en_next);
  end

  // Registers of bus slave and interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      int_st_reg <= '0;
      int_en_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      int_st_reg <= int_st_next;
      int_en_reg <= int_en_next;
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = irq_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_clear_home: assert property ( // see [RQ1]
    (!pins.chip_clear_low && pins.sleep_request_low && !supply_low_lockout)
    |=> ptr_reg == HOME_PTR && !oc_trip_reg)
    else $error("pointer not home under chip clear");
  a_clear_off: assert property ( // see [RQ2]
    !pins.chip_clear_low |=> drive.bridge_en == 2'h0 && drive.outputs_hiz)
    else $error("bridges on under chip clear");
  a_enable_hiz: assert property ( // see [RQ4]
    (pins.output_enable_low && pins.chip_clear_low && !supply_low_lockout)
    |=> drive.outputs_hiz && $stable(ptr_reg))
    else $error("outputs driven or stepping while disabled");
  a_sleep_freeze: assert property ( // see [RQ5]
    (!pins.sleep_request_low && !supply_low_lockout)
    |=> $stable(ptr_reg) && !drive.charge_pump_on && !drive.aux_regulator_on)
    else $error("activity during sleep");
  a_step_move: assert property ( // see [RQ13]
    (step_rise && pins.sleep_request_low && pins.chip_clear_low &&
     !pins.output_enable_low && !supply_low_lockout)
    |=> ptr_reg == step_ptr($past(ptr_reg), $past(dir_s), $past(mode_s)))
    else $error("step did not move by one stride");
  a_oc_trip: assert property ( // see [RQ8]
    (oc_cnt_reg == OC_LAST && |fet_current_limit && pins.chip_clear_low &&
     pins.sleep_request_low && !supply_low_lockout)
    |=> oc_trip_reg && !fault_flag_low && drive.bridge_en == 2'h0)
    else $error("overcurrent dwell did not shut down");
  a_oc_hold: assert property ( // see [RQ9]
    (oc_trip_reg && pins.chip_clear_low && !supply_low_lockout)
    |=> oc_trip_reg)
    else $error("overcurrent latch released early");
  a_thermal_cut: assert property ( // see [RQ11]
    thermal_cutoff |=> !fault_flag_low && drive.bridge_en == 2'h0)
    else $error("thermal cutoff not applied");
  a_supply_reset: assert property ( // see [RQ12]
    supply_low_lockout |=> ptr_reg == HOME_PTR && !oc_trip_reg &&
    !drive.charge_pump_on)
    else $error("lockout did not reset logic");
  a_table_315: assert property ( // see [RQ16]
    ptr_reg == 7'h70 |=> coil_a == 8'sh47 && coil_b == -8'sh47)
    else $error("wrong currents at 315 degrees");
  a_table_270: assert property ( // see [RQ17]
    ptr_reg == 7'h60 |=> coil_a == 8'sh00 && coil_b == -8'sh64)
    else $error("wrong currents at 270 degrees");
endmodule

/* File: test/sic_ctrl_model.sv */
// Controller model driving step, direction, mode and control pins
`timescale 1ns/10ps
module sic_ctrl_model #(
  parameter int WAKE_CYCLES = 100000
) (
  input wire logic aclk,
  output sic_pkg::sic_pins_s pins
);
  import sic_pkg::*;
  // Idle levels: clear and sleep released, outputs enabled
  initial begin
    pins = '0;
    pins.chip_clear_low = 1'b1;
    pins.sleep_request_low = 1'b1;
  end
  // One step; dir and mode settle 3 cycles ahead of the edge
  task automatic step(input logic dir, input logic [2:0] mode);
    @(posedge aclk);
    pins.dir_in <= dir;
    pins.mode <= mode;
    repeat (3) @(posedge aclk);
    pins.step_in <= 1'b1;
    // Pulse kept 2 cycles high and 3 low so the synchroniser sees it
    repeat (2) @(posedge aclk);
    pins.step_in <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // Control pin levels, then a short settle
  task automatic ctl(input logic clr_n, input logic oe_n, input logic slp_n);
    @(posedge aclk);
    pins.chip_clear_low <= clr_n;
    pins.output_enable_low <= oe_n;
    pins.sleep_request_low <= slp_n;
    repeat (3) @(posedge aclk);
  endtask
  // Leave sleep and hold off stepping while the device settles
  task automatic wake();
    @(posedge aclk);
    pins.sleep_request_low <= 1'b1;
    repeat (WAKE_CYCLES) @(posedge aclk);
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the stepper indexer
`timescale 1ns/10ps
module tb;
  import sic_pkg::*;
  localparam int OC = 4; // Short dwell keeps the trip test quick
  logic aclk, aresetn, thermal, supply, fault_low, irq;
  sic_pins_s pins;
  sic_drive_s drive;
  sic_pct_t coil_a, coil_b;
  logic [FET_N-1:0] fet;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [6:0] ptr; // Expected pointer
  int miscompares, checked;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  sic_ctrl_model #(.WAKE_CYCLES(50)) host_u (.aclk(aclk), .pins(pins));
  sic_indexer #(.OC_CYCLES(OC)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .pins(pins), .fet_current_limit(fet),
    .thermal_cutoff(thermal), .supply_low_lockout(supply), .drive(drive),
    .coil_a(coil_a), .coil_b(coil_b), .fault_flag_low(fault_low),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // Bounded waits end the run rather than hang it
  task automatic hang(input string nm);
    miscompares++;
    $display("Error %s timed out", nm);
    test_done();
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask
  // Masked register compare
  task automatic rchk(input logic [31:0] a, input logic [31:0] m,
                      input logic [31:0] ex, input string nm);
    rd(a);
    chk(nm, d & m, ex);
  endtask
  // Hold a current limit for n cycles, then let it settle
  task automatic limit(input logic [FET_N-1:0] b, input int n);
    @(posedge aclk);
    fet <= b;
    repeat (n) @(posedge aclk);
    fet <= '0;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {thermal, supply, awvalid, wvalid, bready, arvalid, rready} = '0;
    {fet, awaddr, wdata, araddr} = '0;
    miscompares = 0;
    checked = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rchk(ADDR_STATUS, 32'h7f, 32'h10, "home ptr");
    chk("bridges on", 32'(drive.bridge_en), 32'h3);
    $display("Reset test done");
    // Three full steps forward land on 315 degrees
    repeat (3) host_u.step(1'b1, SIC_FULL);
    rchk(ADDR_STATUS, 32'h7f, 32'h70, "ptr fwd");
    chk("coil a 315", 32'(coil_a), 32'h47);
    chk("coil b 315", 32'(coil_b), 32'hffff_ffb9);
    host_u.step(1'b0, SIC_HALF);
    chk("coil a 270", 32'(coil_a), 32'h0);
    chk("coil b 270", 32'(coil_b), 32'hffff_ff9c);
    host_u.step(1'b1, SIC_FULL);
    rchk(ADDR_STATUS, 32'h7f, 32'h0, "wrap fwd");
    // Every mode backward, wrapping below zero
    ptr = 7'h0;
    for (int m = 0; m < 6; m++) begin
      host_u.step(1'b0, 3'(m));
      ptr = ptr - (FULL_STRIDE >> m);
      rchk(ADDR_STATUS, 32'h7ff, {21'h0, 3'(m), 1'b0, ptr},
           "stride");
    end
    $display("Step test done");
    host_u.ctl(1'b1, 1'b1, 1'b1);
    chk("oe off", 32'(drive[4:2]), 32'h1);
    host_u.step(1'b1, SIC_THIRTYSECOND);
    rchk(ADDR_STATUS, 32'h7f, 32'(ptr), "oe step");
    host_u.ctl(1'b1, 1'b0, 1'b1);
    chk("oe on", 32'(drive[4:2]), 32'h6);
    host_u.ctl(1'b0, 1'b0, 1'b1);
    chk("clear off", 32'(drive.bridge_en), 32'h0);
    host_u.step(1'b1, SIC_THIRTYSECOND);
    host_u.ctl(1'b1, 1'b0, 1'b1);
    rchk(ADDR_STATUS, 32'h7f, 32'h10, "clear ptr");
    host_u.ctl(1'b1, 1'b0, 1'b0);
    // Sleep: bridges, pump and regulator off, outputs left floating
    chk("sleep drv", 32'(drive), 32'h4);
    host_u.step(1'b1, SIC_THIRTYSECOND);
    host_u.wake();
    rchk(ADDR_STATUS, 32'h7f, 32'h10, "sleep ptr");
    chk("pump on", 32'(drive.charge_pump_on), 32'h1);
    $display("Control test done");
    // A high side and a low side transistor
    for (int b = 0; b < FET_N; b += FET_N - 1) begin
      limit(FET_N'(1) << b, OC - 1);
      chk("no trip", 32'(fault_low), 32'h1);
      limit(FET_N'(1) << b, OC + 1);
      chk("trip fault", 32'(fault_low), 32'h0);
      chk("trip drv", 32'(drive.bridge_en), 32'h0);
      rchk(ADDR_STATUS, 32'h1_0000, 32'h1_0000, "oc latch");
      host_u.ctl(1'b0, 1'b0, 1'b1);
      host_u.ctl(1'b1, 1'b0, 1'b1);
      chk("oc clear", 32'(fault_low), 32'h1);
    end
    @(posedge aclk);
    thermal <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("hot", 32'({fault_low, drive.bridge_en}), 32'h0);
    rchk(ADDR_STATUS, 32'h2_0000, 32'h2_0000, "hot flag");
    thermal <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("cool", 32'({fault_low, drive.bridge_en}), 32'h7);
    host_u.step(1'b1, SIC_FULL);
    @(posedge aclk);
    supply <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("lockout", 32'(drive.charge_pump_on), 32'h0);
    host_u.step(1'b1, SIC_FULL);
    supply <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(ADDR_STATUS, 32'h7f, 32'h10, "lockout ptr");
    $display("Protection test done");
    // Interrupts: masked, enabled, cleared; bus errors
    wr(ADDR_INT_CLEAR, 32'hf);
    rchk(ADDR_INT_STATUS, 32'hffff_ffff, 32'h0, "int clr");
    // Reserved mode code must step like 1/32
    host_u.step(1'b1, 3'h7);
    chk("irq masked", 32'(irq), 32'h0);
    rchk(ADDR_INT_STATUS, 32'hffff_ffff, 32'h8, "int step");
    wr(ADDR_INT_ENABLE, 32'h8);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'(irq), 32'h1);
    rchk(ADDR_INT_ENABLE, 32'hffff_ffff, 32'h8, "int en");
    wr(ADDR_INT_CLEAR, 32'h8);
    repeat (2) @(posedge aclk);
    chk("irq off", 32'(irq), 32'h0);
    wr(32'h40, 32'h1);
    chk("wr unmapped", 32'(resp), 32'(RESP_SLVERR));
    rd(32'h40);
    chk("rd unmapped", {d[29:0], resp}, 32'(RESP_SLVERR));
    wr(ADDR_STATUS, 32'hffff_ffff);
    chk("wr ro", 32'(resp), 32'(RESP_OKAY));
    rchk(ADDR_STATUS, 32'h7f, 32'h11, "ro ptr");
    $display("Register test done");
    test_done();
  end
endmodule
